// >>> dit_pkg.sv
package dit_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int BASE1_US = 1;
  localparam int BASE5_US = 5;
  localparam int BASE25_US = 25;
  localparam int BASE50_US = 50;
  localparam int US_CYC = BASE1_US * CLK_MHZ;
  localparam int DIV5 = BASE5_US / BASE1_US;
  localparam int DIV25 = BASE25_US / BASE5_US;
  localparam int DIV50 = BASE50_US / BASE25_US;
  localparam int FILT_NS = 5000;
  localparam int FILT_CYC = FILT_NS * CLK_MHZ / 1000;
  // ****************************************
  // widths and fields
  // ****************************************
  localparam int CNT_W = 16;
  localparam int NUM_TMR = 2;
  localparam int MODE_W = 5;
  localparam int MODE_BASE_LSB = 0;
  localparam int MODE_GATE_BIT = 3;
  localparam int MODE_PER_BIT = 4;
  localparam logic [2:0] BASE_EXT = 3'h4;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] TMR_STRIDE = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 6'h0c;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] ADR_MASK = 6'h24;
  localparam logic [ADDR_W-1:0] ADR_INFO = 6'h28;
  localparam logic [NUM_TMR-1:0] MASK_RST = 2'h0;
endpackage : dit_pkg

// >>> dit_timer_chan.sv
`timescale 1ns/1ps
module dit_timer_chan
  import dit_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic rst_n_i, // async reset
  input wire logic ce_i, // clock enable
  input wire logic [3:0] base_tick_i, // internal base ticks
  input wire logic ext_clk_i, // raw user clock pin
  input wire logic ext_gate_i, // raw external gate pin
  input wire logic filt_en_i, // filter strap
  input wire logic start_i, // start strobe
  input wire logic stop_i, // stop strobe
  input wire logic mode_we_i, // mode write
  input wire logic cnt_we_i, // count write
  input wire logic rld_we_i, // reload write
  input wire logic [CNT_W-1:0] wdata_i, // write data
  output logic [CNT_W-1:0] count_o, // current count
  output logic [CNT_W-1:0] reload_o, // auto-load value
  output logic [MODE_W-1:0] mode_o, // mode setting
  output logic run_o, // run state
  output logic gate_en_o, // gate enable bit
  output logic uf_o // underflow pulse
);
  // ****************************************
  // state
  // ****************************************
  logic clk_s1_reg, clk_s2_reg, gate_s1_reg, gate_s2_reg;
  logic flt_lvl_reg, flt_lvl_next, prev_reg, prev_next;
  logic [9:0] flt_cnt_reg, flt_cnt_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, rld_reg, rld_next;
  logic [MODE_W-1:0] mode_reg, mode_next;
  logic run_reg, run_next, uf_reg, uf_next;
  logic ext_lvl, tick, gate_ok;
  logic [2:0] base;

  always_comb begin
    flt_lvl_next = flt_lvl_reg;
    flt_cnt_next = '0;
    if (clk_s2_reg != flt_lvl_reg) begin
      flt_cnt_next = flt_cnt_reg + 10'h001;
      if (flt_cnt_reg == 10'(FILT_CYC - 1)) begin
        flt_lvl_next = clk_s2_reg;
        flt_cnt_next = '0;
      end
    end
    ext_lvl = filt_en_i ? flt_lvl_reg : clk_s2_reg;
    prev_next = ext_lvl;
    base = mode_reg[MODE_BASE_LSB +: 3];
    if (base == BASE_EXT) begin
      tick = ext_lvl && !prev_reg;
    end else begin
      tick = base_tick_i[base[1:0]];
    end
    gate_ok = !mode_reg[MODE_GATE_BIT] || gate_s2_reg;
    run_next = (run_reg || start_i) && !stop_i;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    rld_next = rld_we_i ? wdata_i : rld_reg;
    uf_next = 1'b0;
    if (!run_reg && mode_we_i) begin
      mode_next = wdata_i[MODE_W-1:0];
    end
    if (!run_reg && cnt_we_i) begin
      cnt_next = wdata_i;
    end else if (run_reg && gate_ok && tick) begin
      if (cnt_reg == CNT_RST) begin
        uf_next = 1'b1;
        cnt_next = mode_reg[MODE_PER_BIT] ? rld_reg : cnt_reg - 16'h0001;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      flt_lvl_reg <= 1'b0;
      flt_cnt_reg <= '0;
      prev_reg <= 1'b0;
      cnt_reg <= CNT_RST;
      rld_reg <= CNT_RST;
      mode_reg <= MODE_RST;
      run_reg <= 1'b0;
      uf_reg <= 1'b0;
    end else if (ce_i) begin
      clk_s1_reg <= ext_clk_i;
      clk_s2_reg <= clk_s1_reg;
      gate_s1_reg <= ext_gate_i;
      gate_s2_reg <= gate_s1_reg;
      flt_lvl_reg <= flt_lvl_next;
      flt_cnt_reg <= flt_cnt_next;
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
      mode_reg <= mode_next;
      run_reg <= run_next;
      uf_reg <= uf_next;
    end
  end

  assign count_o = cnt_reg;
  assign reload_o = rld_reg;
  assign mode_o = mode_reg;
  assign run_o = run_reg;
  assign gate_en_o = mode_reg[MODE_GATE_BIT];
  assign uf_o = uf_reg;
endmodule : dit_timer_chan

// >>> dit_top.sv
`timescale 1ns/1ps
module dit_top
  import dit_pkg::*;
(
  input wire logic mclk_i, // 100 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic [ADDR_W-1:0] address_i, // byte address
  input wire logic read_i, // read request
  input wire logic write_i, // write request
  input wire logic [3:0] byteenable_i, // byte lanes
  input wire logic [31:0] writedata_i, // write data
  output logic [31:0] readdata_o, // read data
  output logic waitrequest_o, // wait request
  output logic irq_o, // level interrupt
  input wire logic filt_strap_i, // filter strap pin
  input wire logic t0_ext_clk_i, // timer 0 user clock
  input wire logic t0_ext_gate_i, // timer 0 external gate
  input wire logic t1_ext_clk_i, // timer 1 user clock
  input wire logic t1_ext_gate_i, // timer 1 external gate
  output logic t0_run_o, // timer 0 run state
  output logic t0_gate_en_o, // timer 0 gate enable
  output logic t1_run_o, // timer 1 run state
  output logic t1_gate_en_o // timer 1 gate enable
);
  // ****************************************
  // strap capture
  // ****************************************
  logic strap_s1_reg, strap_s2_reg;
  logic filt_reg, filt_next;
  logic [1:0] cap_reg, cap_next;

  // strap taken once, after the synchroniser has filled
  always_comb begin
    filt_next = filt_reg;
    cap_next = cap_reg;
    if (cap_reg != 2'h3) begin
      cap_next = cap_reg + 2'h1;
    end
    if (cap_reg == 2'h2) begin
      filt_next = strap_s2_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      filt_reg <= 1'b0;
      cap_reg <= 2'h0;
    end else if (ce_i) begin
      strap_s1_reg <= filt_strap_i;
      strap_s2_reg <= strap_s1_reg;
      filt_reg <= filt_next;
      cap_reg <= cap_next;
    end
  end

  // ****************************************
  // internal time bases
  // ****************************************
  logic [6:0] pre_reg, pre_next;
  logic [2:0] d5_reg, d5_next, d25_reg, d25_next;
  logic d50_reg, d50_next;
  logic [3:0] tick_reg, tick_next;

  always_comb begin
    pre_next = pre_reg + 7'h01;
    d5_next = d5_reg;
    d25_next = d25_reg;
    d50_next = d50_reg;
    tick_next = 4'h0;
    if (pre_reg == 7'(US_CYC - 1)) begin
      pre_next = 7'h00;
      tick_next[0] = 1'b1;
      d5_next = d5_reg + 3'h1;
      if (d5_reg == 3'(DIV5 - 1)) begin
        d5_next = 3'h0;
        tick_next[1] = 1'b1;
        d25_next = d25_reg + 3'h1;
        if (d25_reg == 3'(DIV25 - 1)) begin
          d25_next = 3'h0;
          tick_next[2] = 1'b1;
          d50_next = !d50_reg;
          if (d50_reg == 1'(DIV50 - 1)) begin
            tick_next[3] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= 7'h00;
      d5_reg <= 3'h0;
      d25_reg <= 3'h0;
      d50_reg <= 1'b0;
      tick_reg <= 4'h0;
    end else if (ce_i) begin
      pre_reg <= pre_next;
      d5_reg <= d5_next;
      d25_reg <= d25_next;
      d50_reg <= d50_next;
      tick_reg <= tick_next;
    end
  end

  // ****************************************
  // bus handshake and decode
  // ****************************************
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic req, acc, wr_acc, rd_acc;
  logic [ADDR_W-1:0] ofs;
  logic tsel;
  logic tmr_hit;
  logic [CNT_W-1:0] wdata16;

  assign req = read_i || write_i;
  assign acc = req && !wait_reg;
  assign wr_acc = acc && write_i;
  assign rd_acc = acc && read_i;
  assign tmr_hit = address_i < ADR_STATUS;
  assign tsel = address_i[4];
  assign ofs = address_i & (TMR_STRIDE - 6'h01);
  assign wdata16 = writedata_i[CNT_W-1:0] & {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // ****************************************
  // timers
  // ****************************************
  logic [NUM_TMR-1:0] start_s, stop_s, mode_we, cnt_we, rld_we;
  logic [NUM_TMR-1:0] run_w, gate_w, uf_w, ext_clk_w, ext_gate_w;
  logic [CNT_W-1:0] cnt_w [NUM_TMR];
  logic [CNT_W-1:0] rld_w [NUM_TMR];
  logic [MODE_W-1:0] mode_w [NUM_TMR];

  assign ext_clk_w = {t1_ext_clk_i, t0_ext_clk_i};
  assign ext_gate_w = {t1_ext_gate_i, t0_ext_gate_i};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
      logic sel;
      assign sel = wr_acc && tmr_hit && (tsel == 1'(gi));
      assign start_s[gi] = sel && (ofs == OFS_CTRL) && writedata_i[CTRL_START_BIT];
      assign stop_s[gi] = sel && (ofs == OFS_CTRL) && writedata_i[CTRL_STOP_BIT];
      assign mode_we[gi] = sel && (ofs == OFS_MODE);
      assign cnt_we[gi] = sel && (ofs == OFS_COUNT);
      assign rld_we[gi] = sel && (ofs == OFS_RELOAD);
      dit_timer_chan u_chan (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .base_tick_i(tick_reg),
        .ext_clk_i(ext_clk_w[gi]),
        .ext_gate_i(ext_gate_w[gi]),
        .filt_en_i(filt_reg),
        .start_i(start_s[gi]),
        .stop_i(stop_s[gi]),
        .mode_we_i(mode_we[gi]),
        .cnt_we_i(cnt_we[gi]),
        .rld_we_i(rld_we[gi]),
        .wdata_i(wdata16),
        .count_o(cnt_w[gi]),
        .reload_o(rld_w[gi]),
        .mode_o(mode_w[gi]),
        .run_o(run_w[gi]),
        .gate_en_o(gate_w[gi]),
        .uf_o(uf_w[gi])
      );
    end
  endgenerate

  assign t0_run_o = run_w[0];
  assign t1_run_o = run_w[1];
  assign t0_gate_en_o = gate_w[0];
  assign t1_gate_en_o = gate_w[1];

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [NUM_TMR-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic irq_reg, irq_next;

  always_comb begin
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (rd_acc && address_i == ADR_STATUS) begin
      // clear only what this read reported
      stat_next = stat_reg & ~rdata_reg[NUM_TMR-1:0];
    end
    stat_next = stat_next | uf_w;
    if (wr_acc && address_i == ADR_MASK && byteenable_i[0]) begin
      mask_next = writedata_i[NUM_TMR-1:0];
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_reg <= '0;
      mask_reg <= MASK_RST;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // read data and wait
  // ****************************************
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if (req && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0000_0000;
      if (tmr_hit) begin
        unique case (ofs)
          OFS_CTRL: rdata_next[CTRL_START_BIT] = run_w[tsel];
          OFS_MODE: rdata_next[MODE_W-1:0] = mode_w[tsel];
          OFS_COUNT: rdata_next[CNT_W-1:0] = cnt_w[tsel];
          OFS_RELOAD: rdata_next[CNT_W-1:0] = rld_w[tsel];
          default: rdata_next = 32'h0000_0000;
        endcase
      end else if (address_i == ADR_STATUS) begin
        rdata_next[NUM_TMR-1:0] = stat_reg;
      end else if (address_i == ADR_MASK) begin
        rdata_next[NUM_TMR-1:0] = mask_reg;
      end else if (address_i == ADR_INFO) begin
        rdata_next[0] = filt_reg;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign waitrequest_o = wait_reg;
  assign readdata_o = rdata_reg;
  assign irq_o = irq_reg;
endmodule : dit_top

// >>> dit_chk.sv
`timescale 1ns/1ps
module dit_chk
  import dit_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic [ADDR_W-1:0] address_i, // byte address
  input wire logic read_i, // read request
  input wire logic write_i, // write request
  input wire logic [31:0] writedata_i, // write data
  input wire logic [31:0] readdata_o, // read data
  input wire logic waitrequest_o, // wait request
  input wire logic irq_o, // interrupt
  input wire logic t0_run_o, // timer 0 run
  input wire logic t0_gate_en_o, // timer 0 gate enable
  input wire logic t1_run_o // timer 1 run
);
  // ****************************************
  // bus and timer state checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_ok;
  logic acc;
  assign wr_ok = write_i && !waitrequest_o;
  assign acc = read_i || write_i;
  property p_ans; acc && waitrequest_o |=> !waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one; !waitrequest_o |=> waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_irq_fall; $fell(irq_o) |-> $past(acc, 1) || $past(acc, 2) || $past(acc, 3); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
  property p_run0; $rose(t0_run_o) |-> $past(wr_ok) && $past(address_i) == OFS_CTRL; endproperty
  a_run0: assert property (p_run0) else $error("t0 started without write");
  property p_run1; $fell(t1_run_o) |-> $past(wr_ok) && $past(address_i) == TMR_STRIDE; endproperty
  a_run1: assert property (p_run1) else $error("t1 stopped without write");
  property p_gate; $changed(t0_gate_en_o) |-> $past(wr_ok) && $past(address_i) == OFS_MODE; endproperty
  a_gate: assert property (p_gate) else $error("gate enable moved");
  property p_rd; read_i |=> $stable(t0_run_o) && $stable(t1_run_o); endproperty
  a_rd: assert property (p_rd) else $error("read disturbed run");
  property p_rdh; waitrequest_o && $past(waitrequest_o) |-> $stable(readdata_o); endproperty
  a_rdh: assert property (p_rdh) else $error("read data moved");
endmodule : dit_chk
bind dit_top dit_chk u_dit_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .irq_o(irq_o), .t0_run_o(t0_run_o),
  .t0_gate_en_o(t0_gate_en_o), .t1_run_o(t1_run_o));

// >>> dit_pulse_src.sv
`timescale 1ns/1ps
module dit_pulse_src (
  input wire logic mclk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic go_i, // start a burst
  input wire logic [3:0] npulse_i, // pulses in burst
  output logic pin_o, // user clock pin
  output logic busy_o // burst in progress
);
  // ****************************************
  // user clock source, still between bursts
  // ****************************************
  logic [3:0] rem;
  logic [7:0] ph;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rem <= 4'h0;
      ph <= 8'h00;
    end else if (go_i) begin
      rem <= npulse_i;
      ph <= 8'h00;
    end else if (rem != 4'h0) begin
      ph <= (ph == 8'hc7) ? 8'h00 : ph + 8'h01;
      if (ph == 8'hc7) rem <= rem - 4'h1;
    end
  end
  assign pin_o = (rem != 4'h0) && (ph < 8'h64);
  assign busy_o = rem != 4'h0;
endmodule : dit_pulse_src

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(g, e) chk_val(32'(g), 32'(e))
module tb;
  import dit_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, read_i = 0, write_i = 0, gate1 = 0, go = 0, ce = 1, strap = 0;
  logic [ADDR_W-1:0] address_i = '0;
  logic [31:0] writedata_i = '0;
  logic [3:0] npulse = 4'h0;
  logic [31:0] readdata_o, q;
  logic waitrequest_o, irq_o, t0_run_o, t0_gate_en_o, t1_run_o, t1_gate_en_o, pin1, busy;
  int err_count = 0, samples_checked = 0;
  dit_top u_dit_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(4'hf), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o), .filt_strap_i(strap),
    .t0_ext_clk_i(1'b0), .t0_ext_gate_i(1'b0), .t1_ext_clk_i(pin1), .t1_ext_gate_i(gate1),
    .t0_run_o(t0_run_o), .t0_gate_en_o(t0_gate_en_o), .t1_run_o(t1_run_o), .t1_gate_en_o(t1_gate_en_o));
  dit_pulse_src u_dit_pulse_src (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go), .npulse_i(npulse),
    .pin_o(pin1), .busy_o(busy));
  // ****************************************
  // bus and check helpers
  // ****************************************
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  task pulses(input logic [3:0] n);
    @(posedge mclk_i);
    go <= 1'b1;
    npulse <= n;
    @(posedge mclk_i);
    go <= 1'b0;
    do @(posedge mclk_i); while (busy !== 1'b0);
    repeat (10) @(posedge mclk_i);
  endtask : pulses
  task test_done;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // ****************************************
  // scenarios
  // ****************************************
  task s_reset;
    `CHK({t0_run_o, t0_gate_en_o, t1_run_o, t1_gate_en_o, irq_o}, 0);
    bus(1, 6'h30, 32'h1);
    bus(0, 6'h30, 0); `CHK(q, 0);
    bus(0, ADR_INFO, 0); `CHK(q, 0);
    bus(0, ADR_MASK, 0); `CHK(q, 0);
  endtask : s_reset
  task s_bases;
    int per[4] = '{1, 5, 25, 50};
    int e;
    logic [15:0] dl;
    for (int b = 0; b < 4; b++) begin
      bus(1, OFS_MODE, b);
      bus(1, OFS_COUNT, 32'h1000);
      bus(1, OFS_CTRL, 32'h1);
      @(posedge mclk_i);
      `CHK({t0_run_o, t1_run_o}, 2'b10);
      repeat (5000) @(posedge mclk_i);
      bus(1, OFS_CTRL, 32'h2);
      bus(0, OFS_COUNT, 0);
      dl = 16'h1000 - q[15:0];
      e = 50 / per[b];
      `CHK(dl >= e - 1 && dl <= e + 1, 1);
    end
  endtask : s_bases
  task s_aper;
    int n;
    bus(1, ADR_MASK, 32'h3);
    bus(1, OFS_MODE, 0);
    bus(1, OFS_COUNT, 32'h2);
    bus(1, OFS_CTRL, 32'h1);
    bus(1, OFS_MODE, 32'h8);
    @(posedge mclk_i);
    `CHK(t0_gate_en_o, 0);
    n = 0;
    while (irq_o !== 1'b1 && n < 600) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK(irq_o, 1);
    bus(0, ADR_STATUS, 0); `CHK(q, 1);
    repeat (4) @(posedge mclk_i);
    `CHK(irq_o, 0);
    bus(0, OFS_COUNT, 0); `CHK(q[15:8], 8'hff);
    `CHK(t0_run_o, 1);
    bus(1, OFS_CTRL, 32'h2);
    bus(1, OFS_MODE, 32'h8);
    @(posedge mclk_i);
    `CHK({t0_run_o, t0_gate_en_o}, 2'b01);
  endtask : s_aper
  task s_ext;
    bus(1, TMR_STRIDE + OFS_MODE, 32'h1c);
    bus(1, TMR_STRIDE + OFS_RELOAD, 32'h2);
    bus(1, TMR_STRIDE + OFS_COUNT, 32'h1);
    bus(1, TMR_STRIDE + OFS_CTRL, 32'h1);
    @(posedge mclk_i);
    `CHK({t1_run_o, t1_gate_en_o}, 2'b11);
    pulses(3);
    bus(0, TMR_STRIDE + OFS_COUNT, 0); `CHK(q, 1);
    gate1 <= 1'b1;
    pulses(2);
    bus(0, TMR_STRIDE + OFS_COUNT, 0); `CHK(q, 2);
    bus(0, ADR_STATUS, 0); `CHK(q, 2);
    pulses(3);
    bus(0, ADR_STATUS, 0); `CHK(q, 2);
    bus(1, TMR_STRIDE + OFS_CTRL, 32'h2);
    @(posedge mclk_i);
    `CHK(t1_run_o, 0);
  endtask : s_ext
  task s_hold;
    bus(1, OFS_MODE, 0);
    bus(1, OFS_COUNT, 32'h100);
    bus(1, OFS_CTRL, 32'h1);
    ce <= 1'b0;
    repeat (300) @(posedge mclk_i);
    `CHK({t0_run_o, waitrequest_o}, 2'h3);
    ce <= 1'b1;
    bus(0, OFS_COUNT, 0); `CHK(q[15:0] >= 16'h00ff, 1);
    bus(1, OFS_CTRL, 32'h2);
  endtask : s_hold
  task s_strap;
    strap <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    `CHK({t0_run_o, t0_gate_en_o, t1_run_o, t1_gate_en_o, irq_o, waitrequest_o}, 6'h01);
    bus(0, ADR_INFO, 0); `CHK(q, 1);
  endtask : s_strap
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    s_reset();
    s_bases();
    s_aper();
    s_ext();
    s_hold();
    s_strap();
    test_done();
  end
  initial begin
    #400000;
    err_count++;
    test_done();
  end
endmodule : tb
